/* File: logic/readout_mode_context_b.sv */
// read mode control for the second readout context with an AHB-Lite register slave
//
// Contract
// - With the XOR bit set, line valid is the continuous line signal XOR frame valid.
// - Continuous or XOR mode keeps line pulses through vertical blanking, else none there; oversize without show-border blanks them there too.
// - Context B power bit selects low-power readout at half the master clock rate.
// - Oversize adds a four-pixel border on every side, eight rows and columns more.
// - With oversize set, show-border makes border pixels active or blanking.
// - Column 4x skip reads two columns then skips six.
// - Row 4x skip reads two rows then skips six.
// - Context B column 2x skip reads two columns then skips two.
// - Context B row 2x skip reads two rows then skips two.
// - Column mirror scans from start+size down to start+1, else start up to start+size-1.
// - Row mirror scans from start+size down to start+1, else start up to start+size-1.
// - While the hold bit is set, frame-synchronised changes are deferred.
// - Unless show-bad-frames is set, the first frame after a readout change is suppressed.
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
module readout_mode_context_b (
    input wire logic clock,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output readout_pkg::pix_t pixOut
);
    // ========================================
    // reset release
    logic rstSync1_r;
    logic rstSync2_r;
    logic rstn;

    // async assert, clocked release through two flops
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rstSync1_r <= 1'b0;
            rstSync2_r <= 1'b0;
        end else begin
            rstSync1_r <= 1'b1;
            rstSync2_r <= rstSync1_r;
        end
    end
    assign rstn = rstSync2_r;

    // ========================================
    // bus slave
    logic [15:0] modeB_r;
    logic [15:0] modeA_r;
    logic [2:0] ctrl_r;
    readout_pkg::win_t win_r;
    readout_pkg::mode_t act_r;
    readout_pkg::win_t actWin_r;
    logic suppress_r;
    logic wrPend_r;
    logic [7:0] wrAddr_r;
    logic addrPhase;
    logic [31:0] rdNxt;
    logic [15:0] statusWord;

    assign addrPhase = hsel && htrans[1] && hready;
    assign statusWord = {act_r, 6'h00, suppress_r, pixOut.frameValid};

    // read data is looked up in the address phase so hrdata comes from a flop
    always_comb begin
        rdNxt = 32'h0000_0000;
        unique case (haddr[7:0])
            readout_pkg::OFF_MODE_B: rdNxt = {16'h0000, modeB_r};
            readout_pkg::OFF_MODE_A: rdNxt = {16'h0000, modeA_r};
            readout_pkg::OFF_CTRL: rdNxt = {29'h0, ctrl_r};
            readout_pkg::OFF_COLWIN: rdNxt = {5'h0, win_r.colSize, 5'h0, win_r.colStart};
            readout_pkg::OFF_ROWWIN: rdNxt = {5'h0, win_r.rowSize, 5'h0, win_r.rowStart};
            readout_pkg::OFF_STATUS: rdNxt = {16'h0000, statusWord};
            default: rdNxt = 32'h0000_0000;
        endcase
        if (haddr[31:8] != 24'h000000) begin
            rdNxt = 32'h0000_0000;
        end
    end

    // zero wait states, always OKAY; unmapped reads give zero
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b0; // no transfer is taken until the bus flops leave reset
            hresp <= 1'b0;
            wrPend_r <= 1'b0;
            wrAddr_r <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wrPend_r <= addrPhase && hwrite && haddr[31:8] == 24'h000000;
            if (addrPhase) begin
                wrAddr_r <= haddr[7:0];
                if (!hwrite) begin
                    hrdata <= rdNxt;
                end
            end
        end
    end

    // data-phase writes; unmapped writes are dropped
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            modeB_r <= readout_pkg::RST_MODE_B;
            modeA_r <= readout_pkg::RST_MODE_A;
            ctrl_r <= readout_pkg::RST_CTRL;
            win_r <= {readout_pkg::RST_COL_START, readout_pkg::RST_COL_SIZE,
                      readout_pkg::RST_ROW_START, readout_pkg::RST_ROW_SIZE};
        end else if (wrPend_r) begin
            unique case (wrAddr_r)
                readout_pkg::OFF_MODE_B: modeB_r <= hwdata[15:0];
                readout_pkg::OFF_MODE_A: modeA_r <= hwdata[15:0];
                readout_pkg::OFF_CTRL: ctrl_r <= hwdata[2:0];
                readout_pkg::OFF_COLWIN: begin
                    win_r.colStart <= hwdata[readout_pkg::B_WIN_START +: readout_pkg::AW];
                    win_r.colSize <= hwdata[readout_pkg::B_WIN_SIZE +: readout_pkg::AW];
                end
                readout_pkg::OFF_ROWWIN: begin
                    win_r.rowStart <= hwdata[readout_pkg::B_WIN_START +: readout_pkg::AW];
                    win_r.rowSize <= hwdata[readout_pkg::B_WIN_SIZE +: readout_pkg::AW];
                end
                default: ;
            endcase
        end
    end

    // ========================================
    // mode selection and frame-boundary shadowing
    readout_pkg::mode_t pend;
    logic ctxB;
    logic frameEnd;
    logic xorLv;
    logic contLv;
    logic showBorder;

    assign ctxB = ctrl_r[readout_pkg::B_CTX_SEL];
    assign xorLv = modeB_r[readout_pkg::B_XOR_LV];
    assign contLv = modeB_r[readout_pkg::B_CONT_LV];
    assign showBorder = modeB_r[readout_pkg::B_SHOW_BORDER];

    always_comb begin
        pend.lowPower = ctxB ? modeB_r[readout_pkg::B_LOW_POWER]
                             : modeA_r[readout_pkg::B_LOW_POWER];
        pend.colSkip2 = ctxB ? modeB_r[readout_pkg::B_COL_SKIP2]
                             : modeA_r[readout_pkg::B_COL_SKIP2];
        pend.rowSkip2 = ctxB ? modeB_r[readout_pkg::B_ROW_SKIP2]
                             : modeA_r[readout_pkg::B_ROW_SKIP2];
        pend.oversize = modeB_r[readout_pkg::B_OVERSIZE];
        pend.colSkip4 = modeB_r[readout_pkg::B_COL_SKIP4];
        pend.rowSkip4 = modeB_r[readout_pkg::B_ROW_SKIP4];
        pend.mirrorCol = modeB_r[readout_pkg::B_MIRROR_COL];
        pend.mirrorRow = modeB_r[readout_pkg::B_MIRROR_ROW];
    end

    // hold defers the update; held changes land at a later boundary
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            act_r <= '0;
            actWin_r <= {readout_pkg::RST_COL_START, readout_pkg::RST_COL_SIZE,
                         readout_pkg::RST_ROW_START, readout_pkg::RST_ROW_SIZE};
        end else if (frameEnd && !ctrl_r[readout_pkg::B_HOLD_SYNC]) begin
            act_r <= pend;
            actWin_r <= win_r;
        end
    end

    // bad frame masking; a change only counts when it is applied
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            suppress_r <= 1'b0;
        end else if (frameEnd) begin
            suppress_r <= !ctrl_r[readout_pkg::B_HOLD_SYNC] &&
                          !ctrl_r[readout_pkg::B_SHOW_BAD] &&
                          (pend != act_r || win_r != actWin_r);
        end
    end

    // ========================================
    // scan sequencing
    readout_pkg::scan_state_t state_r;
    logic half_r;
    logic pixEn;
    logic [7:0] hbCnt_r;
    logic [7:0] vbCnt_r;
    logic inVb_r;
    logic colLoad;
    logic colStep;
    logic rowLoad;
    logic rowStep;
    logic colLast;
    logic rowLast;
    logic colEdge;
    logic rowEdge;
    logic lineEnd;
    logic [readout_pkg::AW-1:0] colAddr;
    logic [readout_pkg::AW-1:0] rowAddr;

    // low power halves the pixel rate
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            half_r <= 1'b0;
        end else begin
            half_r <= !half_r;
        end
    end
    assign pixEn = !act_r.lowPower || half_r;

    assign colStep = state_r == readout_pkg::ST_LINE && pixEn;
    assign lineEnd = colStep && colLast;
    assign colLoad = state_r == readout_pkg::ST_HBLANK && hbCnt_r == readout_pkg::HBLANK_CYC;
    assign rowStep = lineEnd && !inVb_r && !rowLast;
    assign frameEnd = lineEnd && !inVb_r && rowLast;
    assign rowLoad = lineEnd && inVb_r && vbCnt_r == readout_pkg::VBLANK_LINES - 8'h01;

    // line run, then horizontal blanking; lines keep running in vertical blanking
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= readout_pkg::ST_HBLANK;
            hbCnt_r <= 8'h00;
        end else begin
            unique case (state_r)
                readout_pkg::ST_LINE: begin
                    hbCnt_r <= 8'h00;
                    if (lineEnd) begin
                        state_r <= readout_pkg::ST_HBLANK;
                    end
                end
                readout_pkg::ST_HBLANK: begin
                    hbCnt_r <= hbCnt_r + 8'h01;
                    if (colLoad) begin
                        state_r <= readout_pkg::ST_LINE;
                    end
                end
            endcase
        end
    end

    // vertical blanking line count
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            inVb_r <= 1'b1;
            vbCnt_r <= 8'h00;
        end else if (frameEnd) begin
            inVb_r <= 1'b1;
            vbCnt_r <= 8'h00;
        end else if (rowLoad) begin
            inVb_r <= 1'b0;
        end else if (lineEnd && inVb_r) begin
            vbCnt_r <= vbCnt_r + 8'h01;
        end
    end

    scan_axis #(.AW(readout_pkg::AW)) colAxis (
        .clock(clock),
        .rstn(rstn),
        .load(colLoad),
        .step(colStep),
        .base(actWin_r.colStart),
        .size(actWin_r.colSize),
        .mirror(act_r.mirrorCol),
        .skip2(act_r.colSkip2),
        .skip4(act_r.colSkip4),
        .border(act_r.oversize),
        .addr(colAddr),
        .edgePix(colEdge),
        .last(colLast)
    );

    scan_axis #(.AW(readout_pkg::AW)) rowAxis (
        .clock(clock),
        .rstn(rstn),
        .load(rowLoad),
        .step(rowStep),
        .base(actWin_r.rowStart),
        .size(actWin_r.rowSize),
        .mirror(act_r.mirrorRow),
        .skip2(act_r.rowSkip2),
        .skip4(act_r.rowSkip4),
        .border(act_r.oversize),
        .addr(rowAddr),
        .edgePix(rowEdge),
        .last(rowLast)
    );

    // ========================================
    // stream outputs
    logic fvNxt;
    logic lineRaw;
    logic isBorder;
    logic lvNxt;

    // border pixels come from the axis border phases
    assign isBorder = act_r.oversize && (colEdge || rowEdge);
    assign lineRaw = state_r == readout_pkg::ST_LINE && !(isBorder && !showBorder);
    assign fvNxt = !inVb_r && !suppress_r;

    always_comb begin
        if (xorLv) begin
            lvNxt = lineRaw ^ fvNxt;
        end else if (contLv) begin
            lvNxt = lineRaw && (inVb_r || !suppress_r);
        end else begin
            lvNxt = lineRaw && fvNxt;
        end
    end

    // registered so every stream output comes from a flop
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pixOut <= '0;
        end else begin
            pixOut.frameValid <= fvNxt;
            pixOut.lineValid <= lvNxt;
            pixOut.pixelValid <= lineRaw && fvNxt && pixEn;
            pixOut.border <= isBorder;
            pixOut.row <= rowAddr;
            pixOut.col <= colAddr;
        end
    end
endmodule

/* File: logic/readout_pkg.sv */
// shared constants and types for the second-context read mode block
package readout_pkg;
    // register byte addresses
    localparam logic [7:0] OFF_MODE_B = 8'h20;
    localparam logic [7:0] OFF_MODE_A = 8'h24;
    localparam logic [7:0] OFF_CTRL = 8'h28;
    localparam logic [7:0] OFF_COLWIN = 8'h2C;
    localparam logic [7:0] OFF_ROWWIN = 8'h30;
    localparam logic [7:0] OFF_STATUS = 8'h34;
    // read mode field positions
    localparam int B_XOR_LV = 15;
    localparam int B_CONT_LV = 14;
    localparam int B_LOW_POWER = 10;
    localparam int B_SHOW_BORDER = 9;
    localparam int B_OVERSIZE = 8;
    localparam int B_COL_SKIP4 = 5;
    localparam int B_ROW_SKIP4 = 4;
    localparam int B_COL_SKIP2 = 3;
    localparam int B_ROW_SKIP2 = 2;
    localparam int B_MIRROR_COL = 1;
    localparam int B_MIRROR_ROW = 0;
    // control field positions
    localparam int B_CTX_SEL = 0;
    localparam int B_HOLD_SYNC = 1;
    localparam int B_SHOW_BAD = 2;
    // window field positions
    localparam int B_WIN_START = 0;
    localparam int B_WIN_SIZE = 16;
    localparam int AW = 11;
    // reset values
    localparam logic [15:0] RST_MODE_B = 16'h0300;
    localparam logic [15:0] RST_MODE_A = 16'h040C;
    localparam logic [2:0] RST_CTRL = 3'h0;
    localparam logic [AW-1:0] RST_COL_START = 11'h010;
    localparam logic [AW-1:0] RST_COL_SIZE = 11'h040;
    localparam logic [AW-1:0] RST_ROW_START = 11'h008;
    localparam logic [AW-1:0] RST_ROW_SIZE = 11'h030;
    // timing counts in master clock cycles and lines
    localparam logic [7:0] HBLANK_CYC = 8'h10;
    localparam logic [7:0] VBLANK_LINES = 8'h04;
    localparam logic [1:0] BORDER_LAST = 2'h3;
    // frame-synchronised mode fields after context selection
    typedef struct packed {
        logic lowPower;
        logic oversize;
        logic colSkip4;
        logic rowSkip4;
        logic colSkip2;
        logic rowSkip2;
        logic mirrorCol;
        logic mirrorRow;
    } mode_t;
    typedef struct packed {
        logic [AW-1:0] colStart;
        logic [AW-1:0] colSize;
        logic [AW-1:0] rowStart;
        logic [AW-1:0] rowSize;
    } win_t;
    // pixel stream toward downstream capture
    typedef struct packed {
        logic frameValid;
        logic lineValid;
        logic pixelValid;
        logic border;
        logic [AW-1:0] row;
        logic [AW-1:0] col;
    } pix_t;
    typedef enum logic [0:0] {
        ST_LINE = 1'b0,
        ST_HBLANK = 1'b1
    } scan_state_t;
endpackage

/* File: logic/scan_axis.sv */
// one scan axis: border, skipping and mirrored address sequence
`timescale 1ns/10ps
module scan_axis #(
    parameter int AW = 11
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic load,
    input wire logic step,
    input wire logic [AW-1:0] base,
    input wire logic [AW-1:0] size,
    input wire logic mirror,
    input wire logic skip2,
    input wire logic skip4,
    input wire logic border,
    output logic [AW-1:0] addr,
    output logic edgePix,
    output logic last
);
    logic [AW-1:0] first;
    logic [AW-1:0] off;
    logic [AW-1:0] stride;
    logic [AW:0] fwdNext;
    logic [AW:0] fwdEnd;
    logic bodyEnd;
    logic [1:0] phase_r;
    logic [1:0] cnt_r;

    // pairs of two are read, then the skip gap jumps over the rest
    assign first = mirror ? base + size : base;
    assign off = mirror ? first - addr : addr - first;
    assign stride = !off[0] ? 11'h001 : skip4 ? 11'h007 : skip2 ? 11'h003 : 11'h001;
    assign fwdNext = {1'b0, addr} + {1'b0, stride};
    assign fwdEnd = {1'b0, base} + {1'b0, size};
    // mirrored runs stop at base+1, forward runs at base+size-1
    assign bodyEnd = mirror ? ({1'b0, addr} < {1'b0, base} + {1'b0, stride} + 12'h001)
                            : (fwdNext >= fwdEnd);
    assign edgePix = phase_r != 2'h1;
    assign last = (phase_r == 2'h2 && cnt_r == readout_pkg::BORDER_LAST) ||
                  (phase_r == 2'h1 && bodyEnd && !border);

    // phase 0 leading border, 1 body, 2 trailing border
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            phase_r <= 2'h1;
            cnt_r <= 2'h0;
            addr <= '0;
        end else if (load) begin
            phase_r <= border ? 2'h0 : 2'h1;
            cnt_r <= 2'h0;
            addr <= first;
        end else if (step) begin
            unique case (phase_r)
                2'h0: begin
                    cnt_r <= cnt_r + 2'h1;
                    if (cnt_r == readout_pkg::BORDER_LAST) begin
                        phase_r <= 2'h1;
                    end
                end
                2'h1: begin
                    if (bodyEnd) begin
                        if (border) begin
                            phase_r <= 2'h2;
                        end
                    end else begin
                        addr <= mirror ? addr - stride : fwdNext[AW-1:0];
                    end
                end
                default: begin
                    if (cnt_r != readout_pkg::BORDER_LAST) begin
                        cnt_r <= cnt_r + 2'h1;
                    end
                end
            endcase
        end
    end
endmodule

/* File: bench/readout_checker.sv */
// port checker for the read mode block
`timescale 1ns/10ps
module readout_checker (
    input wire logic clock,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire readout_pkg::pix_t pixOut
);
    logic wrPend_r, rdBad_r, fvOld_r, ctxB_r, ok, lp, hold_r;
    logic [7:0] wrAddr_r;
    logic [15:0] mode_r;
    logic [1:0] age_r;
    logic [31:0] colWin_r;
    logic [10:0] cOff;
    // settled two frame starts after a write, so the applied mode is known
    assign ok = age_r == 2'h2;
    assign lp = ctxB_r ? mode_r[10] : readout_pkg::RST_MODE_A[10];
    assign cOff = pixOut.col - colWin_r[10:0];
    // ==========
    // register shadow
    // writes decoded at the ports, since the registers are out of sight
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wrPend_r <= 1'b0;
            rdBad_r <= 1'b0;
            fvOld_r <= 1'b0;
            age_r <= 2'h0;
            {hold_r, ctxB_r} <= 2'h0;
            mode_r <= readout_pkg::RST_MODE_B;
            colWin_r <= {5'h0, readout_pkg::RST_COL_SIZE, 5'h0, readout_pkg::RST_COL_START};
        end else begin
            wrPend_r <= hsel && htrans[1] && hready && hwrite && haddr[31:8] == 24'h0;
            rdBad_r <= hsel && htrans[1] && hready && !hwrite && haddr[31:8] != 24'h0;
            wrAddr_r <= haddr[7:0];
            fvOld_r <= pixOut.frameValid;
            if ((wrPend_r && hready) || hold_r)
                age_r <= 2'h0;
            else if (pixOut.frameValid && !fvOld_r && age_r != 2'h2)
                age_r <= age_r + 2'h1;
            if (wrPend_r && hready && wrAddr_r == readout_pkg::OFF_MODE_B)
                mode_r <= hwdata[15:0];
            if (wrPend_r && hready && wrAddr_r == readout_pkg::OFF_CTRL)
                {hold_r, ctxB_r} <= hwdata[1:0];
            if (wrPend_r && hready && wrAddr_r == readout_pkg::OFF_COLWIN)
                colWin_r <= hwdata;
        end
    end
    // ==========
    // assertions
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    a_ready_held: assert property (hreadyout |=> hreadyout && !hresp)
        else $error("ready dropped or error response");
    a_unmapped_zero: assert property (rdBad_r |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_xor_line: assert property ( // inverted line
        ok && mode_r[15] && pixOut.pixelValid |-> !pixOut.lineValid)
        else $error("xor line valid wrong");
    a_vblank_quiet: assert property ( // quiet blanking
        ok && mode_r[15:14] == 2'h0 && !pixOut.frameValid |-> !pixOut.lineValid)
        else $error("line valid in vertical blanking");
    a_border_shown: assert property ( // border as pixels
        ok && pixOut.pixelValid && pixOut.border |-> mode_r[9] && mode_r[8])
        else $error("border pixel shown wrongly");
    a_col_range: assert property ( // column span
        ok && pixOut.pixelValid && !pixOut.border |->
        cOff <= colWin_r[26:16] && cOff != (mode_r[1] ? 11'h0 : colWin_r[26:16]))
        else $error("column outside scan span");
    a_half_rate: assert property ( // half rate
        ok && lp && pixOut.pixelValid |=> !pixOut.pixelValid)
        else $error("low power pixels back to back");
    a_col_skip: assert property ( // pairs of eight
        ok && mode_r[5] && !mode_r[1] && pixOut.pixelValid && !pixOut.border |->
        cOff[2:1] == 2'h0)
        else $error("column skip pattern wrong");
endmodule

bind readout_mode_context_b readout_checker chk (
    .clock, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .pixOut
);

/* File: bench/pixel_capture.sv */
// downstream capture model gathering per-frame pixel statistics
`timescale 1ns/10ps
module pixel_capture (
    input wire logic clock,
    input wire readout_pkg::pix_t pixOut,
    output int nFrames,
    output int nPix,
    output int firstCol,
    output int lastCol,
    output int firstRow,
    output int lastRow,
    output int maxRun
);
    int cPix, cRun, cMax, fCol, fRow, lCol, lRow;
    logic fvOld = 1'b0;
    initial nFrames = 0;
    // ==========
    // frame statistics
    // no back-pressure exists, so every edge is sampled; results land at frame end
    always @(posedge clock) begin
        if (pixOut.frameValid && !fvOld) begin
            cPix = 0;
            cMax = 0;
        end
        cRun = pixOut.pixelValid ? cRun + 1 : 0;
        if (cRun > cMax)
            cMax = cRun;
        if (pixOut.pixelValid) begin
            if (cPix == 0) begin
                fCol = pixOut.col;
                fRow = pixOut.row;
            end
            lCol = pixOut.col;
            lRow = pixOut.row;
            cPix++;
        end
        if (!pixOut.frameValid && fvOld) begin
            nPix <= cPix;
            firstCol <= fCol;
            lastCol <= lCol;
            firstRow <= fRow;
            lastRow <= lRow;
            maxRun <= cMax;
            nFrames <= nFrames + 1;
        end
        fvOld = pixOut.frameValid;
    end
endmodule

/* File: bench/readout_mode_context_b_tb.sv */
// self-checking bench for the read mode block
`timescale 1ns/10ps
module readout_mode_context_b_tb;
    localparam int CS = 16;
    localparam int RS = 8;
    localparam int SZ = 8;
    localparam logic [15:0] MODES [11] = '{16'h0000, 16'h0002, 16'h0001, 16'h0008,
        16'h0010, 16'h0020, 16'h0404, 16'h0000, 16'h0300, 16'h4000, 16'h8000};
    localparam logic [2:0] CTRLS [11] = '{3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5,
        3'h4, 3'h5, 3'h5, 3'h5};
    logic clock, resetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, v, w;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] lfsr;
    readout_pkg::pix_t pixOut;
    int nMismatch, samplesChecked;
    int nFrames, nPix, firstCol, lastCol, firstRow, lastRow, maxRun;

    readout_mode_context_b dut (
        .clock, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pixOut
    );
    pixel_capture cap (
        .clock, .pixOut, .nFrames, .nPix, .firstCol, .lastCol, .firstRow,
        .lastRow, .maxRun
    );

    // ==========
    // helpers
    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // reference scan of one axis: pairs, then a jump of three or seven
    function automatic void axis(input int st, input logic mir, s2, s4,
                                 output int n, output int first, output int last);
        int p, off, d;
        n = 0;
        off = 0;
        p = mir ? st + SZ : st;
        while (mir ? p >= st + 1 : p <= st + SZ - 1) begin
            if (n == 0)
                first = p;
            last = p;
            n++;
            d = off % 2 == 1 ? (s4 ? 7 : s2 ? 3 : 1) : 1;
            p = mir ? p - d : p + d;
            off++;
        end
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nMismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic testDone();
        $display("comparisons %0d mismatches %0d", samplesChecked, nMismatch);
        if (nMismatch == 0 && samplesChecked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // single bus transfer; the address phase is held until ready is seen
    task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic frames(input int n);
        int k;
        k = nFrames + n;
        for (int i = 0; i < 20000 && nFrames < k; i++)
            @(posedge clock);
        check(nFrames >= k, 1'b1);
    endtask
    // a mode reaches the pixels two frame starts after its write
    task automatic frame_check(input logic [15:0] m, input logic [2:0] c);
        int nc, fc, lc, nr, fr, lr;
        logic lp;
        lp = c[0] ? m[10] : readout_pkg::RST_MODE_A[10];
        axis(CS, m[1], c[0] ? m[3] : readout_pkg::RST_MODE_A[3], m[5], nc, fc, lc);
        axis(RS, m[0], c[0] ? m[2] : readout_pkg::RST_MODE_A[2], m[4], nr, fr, lr);
        frames(3);
        if (m[8]) begin
            check(nPix, (nc + 8) * (nr + 8));
        end else begin
            check(nPix, nc * nr);
            check(firstCol, fc);
            check(lastCol, lc);
            check(firstRow, fr);
            check(lastRow, lr);
            check(maxRun, lp ? 1 : nc);
        end
    endtask

    // ==========
    // clock and watchdog
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // the whole run needs well under this many cycles
    initial begin
        repeat (90000) @(posedge clock);
        nMismatch++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
        testDone();
    end

    // ==========
    // main sequence
    initial begin
        resetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        lfsr = 16'hBBDE;
        nMismatch = 0;
        samplesChecked = 0;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        rd_reset: begin
            xfer(readout_pkg::OFF_MODE_B, 1'b0, 32'h0, v);
            check(v, {16'h0, readout_pkg::RST_MODE_B});
            xfer(readout_pkg::OFF_MODE_A, 1'b0, 32'h0, v);
            check(v, {16'h0, readout_pkg::RST_MODE_A});
        end
        // random words, with a write to an alias above the map that must vanish
        for (int i = 0; i < 4; i++) begin
            lfsr = step(lfsr);
            v = {lfsr, step(lfsr)};
            xfer(readout_pkg::OFF_MODE_B, 1'b1, v, w);
            xfer(32'h120, 1'b1, ~v, w);
            xfer(readout_pkg::OFF_MODE_B, 1'b0, 32'h0, w);
            check(w, {16'h0, v[15:0]});
            xfer(32'h120, 1'b0, 32'h0, w);
            check(w, 32'h0);
        end
        $display("register test done");
        xfer(readout_pkg::OFF_COLWIN, 1'b1, 32'h0008_0010, w);
        xfer(readout_pkg::OFF_ROWWIN, 1'b1, 32'h0008_0008, w);
        for (int i = 0; i < 11; i++) begin
            xfer(readout_pkg::OFF_CTRL, 1'b1, {29'h0, CTRLS[i]}, w);
            xfer(readout_pkg::OFF_MODE_B, 1'b1, {16'h0, MODES[i]}, w);
            frame_check(MODES[i], CTRLS[i]);
            $display("mode test %0d done", i);
        end
        xfer(readout_pkg::OFF_CTRL, 1'b1, 32'h3, w);
        xfer(readout_pkg::OFF_MODE_B, 1'b1, 32'h2, w);
        frames(3);
        check(firstCol, CS);
        xfer(readout_pkg::OFF_CTRL, 1'b1, 32'h1, w);
        frames(1);
        xfer(readout_pkg::OFF_STATUS, 1'b0, 32'h0, w);
        check(w[1], 1'b1);
        frames(2);
        check(firstCol, CS + SZ);
        $display("hold test done");
        testDone();
    end
endmodule
